// >>> src/bcce_axil_slave.sv
// axi4-lite slave turning bus transfers into one-cycle register strobes
`timescale 1ns/1ns
module bcce_axil_slave
  import bcce_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [BCCE_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [BCCE_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  bcce_reg_if.slave regs
);
  logic aw_have_r;
  logic w_have_r;
  logic [BCCE_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic rd_pend_r;
  logic wr_fire;

  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign regs.wr_en = wr_fire;
  assign regs.wr_addr = awaddr_r;
  assign regs.wr_data = wdata_r;
  assign regs.wr_strb = wstrb_r;
  assign regs.rd_en = rd_pend_r;

  // address and data are captured independently, in either order
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BCCE_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= regs.wr_ok ? BCCE_RESP_OKAY : BCCE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // address latched at the handshake: the master may drop it right after
  logic [BCCE_ADDR_W-1:0] araddr_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      rd_pend_r <= 1'b0;
      araddr_r <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= BCCE_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !rd_pend_r && !s_axi_rvalid && s_axi_arvalid;
      rd_pend_r <= s_axi_arvalid && s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_r <= s_axi_araddr;
      end
      if (rd_pend_r) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= regs.rd_data;
        s_axi_rresp <= regs.rd_ok ? BCCE_RESP_OKAY : BCCE_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign regs.rd_addr = araddr_r;
endmodule

// >>> src/bcce_core.sv
// board command, low-power, memory validity and channel activation logic
`timescale 1ns/1ns
// What this block does
// - writing 30 to the command register enters low-power mode
// - reset command or acquisition start leaves low-power mode
// - writing 0 to the command register resets every setting to default except the last run's mask and memory split
// - low-power entry or reset marks sample memory contents invalid
// - channel mask bit 1 picks first input, 2 picks second, used next run
// - only masks 1h and 3h are legal
// - an illegal mask is replaced by the closest legal mask
// - reading the channel register returns the mask in effect
// - sample memory is split evenly among the active inputs
module bcce_core
  import bcce_pkg::*;
#(
  parameter int MEM_AW = 24
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic acq_done,
  bcce_reg_if.core regs,
  output logic low_power,
  output logic mem_valid,
  output logic acq_running,
  output logic acq_start,
  output logic acq_abort,
  output logic [BCCE_CHAN_W-1:0] chan_run_mask,
  output logic [MEM_AW-1:0] chan_mem_words
);
  logic [31:0] cmd_r;
  logic [BCCE_CHAN_W-1:0] chan_r;
  logic [BCCE_CHAN_W-1:0] chan_nxt;
  logic [1:0] nch;
  logic wr_cmd;
  logic wr_chan;
  logic wr_run;
  logic do_reset;
  logic do_lowpwr;
  logic do_start;
  logic do_stop;

  assign wr_cmd = regs.wr_en && regs.wr_addr == BCCE_ADDR_COMMAND && regs.wr_strb[0];
  assign wr_chan = regs.wr_en && regs.wr_addr == BCCE_ADDR_CHAN && regs.wr_strb[0];
  assign wr_run = regs.wr_en && regs.wr_addr == BCCE_ADDR_RUN && regs.wr_strb[0];
  assign do_reset = wr_cmd && regs.wr_data == BCCE_CMD_FULL_RESET;
  assign do_lowpwr = wr_cmd && regs.wr_data == BCCE_CMD_LOW_POWER;
  assign do_start = wr_run && regs.wr_data[BCCE_RUN_START] && !acq_running && !do_stop;
  assign do_stop = wr_run && regs.wr_data[BCCE_RUN_STOP];

  // closest legal mask: any second-input request keeps both, else first alone
  always_comb begin
    chan_nxt = regs.wr_data[1] ? BCCE_MASK_BOTH : BCCE_MASK_FIRST;
  end

  always_comb begin
    regs.wr_ok = !regs.wr_en || wr_cmd || wr_chan || wr_run;
    regs.rd_ok = regs.rd_addr == BCCE_ADDR_COMMAND || regs.rd_addr == BCCE_ADDR_CHAN ||
      regs.rd_addr == BCCE_ADDR_STATUS || regs.rd_addr == BCCE_ADDR_RUN;
    regs.rd_data = '0;
    unique case (regs.rd_addr)
      BCCE_ADDR_COMMAND: regs.rd_data = cmd_r;
      BCCE_ADDR_CHAN: regs.rd_data = {{(32-BCCE_CHAN_W){1'b0}}, chan_r};
      BCCE_ADDR_STATUS: begin
        regs.rd_data[BCCE_ST_LOWPWR] = low_power;
        regs.rd_data[BCCE_ST_MEMVALID] = mem_valid;
        regs.rd_data[BCCE_ST_RUNNING] = acq_running;
        regs.rd_data[BCCE_ST_NCH_LSB +: 2] = nch;
      end
      BCCE_ADDR_RUN: regs.rd_data[BCCE_RUN_START] = acq_running;
      default: regs.rd_data = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd_r <= BCCE_CMD_RESET_VAL;
    end else if (wr_cmd) begin
      cmd_r <= regs.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      chan_r <= BCCE_MASK_RESET;
    end else if (do_reset) begin
      chan_r <= BCCE_MASK_RESET;
    end else if (wr_chan) begin
      chan_r <= chan_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      low_power <= 1'b0;
    end else if (do_lowpwr) begin
      low_power <= 1'b1;
    end else if (do_reset || do_start) begin
      low_power <= 1'b0;
    end
  end

  // a start wins over a done arriving the same cycle; reset/low-power abort first
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acq_running <= 1'b0;
      acq_start <= 1'b0;
      acq_abort <= 1'b0;
      chan_run_mask <= BCCE_MASK_RESET;
    end else begin
      acq_start <= do_start && !do_reset && !do_lowpwr;
      acq_abort <= acq_running && (do_reset || do_lowpwr || do_stop);
      if (do_reset || do_lowpwr || do_stop) begin
        acq_running <= 1'b0;
      end else if (do_start) begin
        acq_running <= 1'b1;
        chan_run_mask <= chan_r;
      end else if (acq_done) begin
        acq_running <= 1'b0;
      end
    end
  end

  // memory becomes valid only once a run has completed
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_valid <= 1'b0;
    end else if (do_reset || do_lowpwr || do_start) begin
      mem_valid <= 1'b0;
    end else if (acq_running && acq_done) begin
      mem_valid <= 1'b1;
    end
  end

  assign nch = {1'b0, chan_run_mask[0]} + {1'b0, chan_run_mask[1]};

  // each active input gets an equal share; with two, half the depth
  // loaded with the run mask so the two never disagree for a cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chan_mem_words <= '1;
    end else if (do_start) begin
      chan_mem_words <= (chan_r == BCCE_MASK_BOTH) ? {1'b0, {(MEM_AW-1){1'b1}}} : '1;
    end
  end
endmodule

// >>> src/bcce_pkg.sv
// package of offsets, commands and defaults for board command and channel control
package bcce_pkg;
  // printed offsets 0 and 11000 are taken as word indexes: byte address = 4 * index
  localparam logic [15:0] BCCE_IDX_COMMAND = 16'h0000;
  localparam logic [15:0] BCCE_IDX_CHAN = 16'h2AF8;
  localparam logic [15:0] BCCE_IDX_STATUS = 16'h2AF9;
  localparam logic [15:0] BCCE_IDX_RUN = 16'h2AFA;
  localparam logic [17:0] BCCE_ADDR_COMMAND = {BCCE_IDX_COMMAND, 2'b00};
  localparam logic [17:0] BCCE_ADDR_CHAN = {BCCE_IDX_CHAN, 2'b00};
  localparam logic [17:0] BCCE_ADDR_STATUS = {BCCE_IDX_STATUS, 2'b00};
  localparam logic [17:0] BCCE_ADDR_RUN = {BCCE_IDX_RUN, 2'b00};
  localparam int BCCE_ADDR_W = 18;
  localparam logic [31:0] BCCE_CMD_FULL_RESET = 32'h0000_0000;
  localparam logic [31:0] BCCE_CMD_LOW_POWER = 32'h0000_001E;
  localparam logic [31:0] BCCE_CMD_RESET_VAL = 32'h0000_0000;
  localparam logic [1:0] BCCE_MASK_FIRST = 2'h1;
  localparam logic [1:0] BCCE_MASK_BOTH = 2'h3;
  localparam logic [1:0] BCCE_MASK_RESET = 2'h1;
  localparam int BCCE_CHAN_W = 2;
  // status bit positions
  localparam int BCCE_ST_LOWPWR = 0;
  localparam int BCCE_ST_MEMVALID = 1;
  localparam int BCCE_ST_RUNNING = 2;
  localparam int BCCE_ST_NCH_LSB = 4;
  // run register bit positions
  localparam int BCCE_RUN_START = 0;
  localparam int BCCE_RUN_STOP = 1;
  localparam logic [1:0] BCCE_RESP_OKAY = 2'b00;
  localparam logic [1:0] BCCE_RESP_SLVERR = 2'b10;
endpackage

// >>> src/bcce_reg_if.sv
// interface carrying decoded register strobes between bus slave and core
`timescale 1ns/1ns
interface bcce_reg_if;
  logic wr_en;
  logic [17:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [17:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_ok, rd_data, rd_ok);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_ok, rd_data, rd_ok);
endinterface

// >>> src/bcce_top.sv
// top: axi4-lite register access to board command and channel activation
`timescale 1ns/1ns
module bcce_top
  import bcce_pkg::*;
#(
  parameter int MEM_AW = 24
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [BCCE_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [BCCE_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic acq_done,
  output logic low_power,
  output logic mem_valid,
  output logic acq_running,
  output logic acq_start,
  output logic acq_abort,
  output logic [BCCE_CHAN_W-1:0] chan_run_mask,
  output logic [MEM_AW-1:0] chan_mem_words
);
  bcce_reg_if regs ();
  bcce_axil_slave u_slave (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .regs(regs.slave)
  );
  bcce_core #(.MEM_AW(MEM_AW)) u_core (
    .clk(clk), .resetn(resetn), .acq_done(acq_done), .regs(regs.core),
    .low_power(low_power), .mem_valid(mem_valid), .acq_running(acq_running),
    .acq_start(acq_start), .acq_abort(acq_abort), .chan_run_mask(chan_run_mask),
    .chan_mem_words(chan_mem_words)
  );
endmodule

// >>> verification/bcce_properties.sv
// port assertions for board command and channel activation
`timescale 1ns/1ns
module bcce_properties
  import bcce_pkg::*;
#(
  parameter int MEM_AW = 24
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic acq_done,
  input wire logic low_power,
  input wire logic mem_valid,
  input wire logic acq_running,
  input wire logic acq_start,
  input wire logic acq_abort,
  input wire logic [BCCE_CHAN_W-1:0] chan_run_mask,
  input wire logic [MEM_AW-1:0] chan_mem_words
);
  localparam logic [MEM_AW-1:0] ALL_WORDS = '1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  lp_idle_a: assert property ($rose(low_power) |-> !acq_running)
    else $error("low power entered with a run active");
  start_wakes_a: assert property (acq_start |=> !low_power)
    else $error("start left board in low power");
  lp_mem_a: assert property (low_power |-> !mem_valid)
    else $error("memory valid during low power");
  start_mem_a: assert property (acq_start |=> !mem_valid)
    else $error("memory still valid after start");
  start_run_a: assert property (acq_start |-> acq_running)
    else $error("start pulse without running");
  mask_legal_a: assert property (chan_run_mask == BCCE_MASK_FIRST
    || chan_run_mask == BCCE_MASK_BOTH)
    else $error("illegal run mask");
  split_one_a: assert property (chan_run_mask == BCCE_MASK_FIRST
    |-> chan_mem_words == ALL_WORDS)
    else $error("single input not given whole memory");
  split_two_a: assert property (chan_run_mask == BCCE_MASK_BOTH
    |-> chan_mem_words == (ALL_WORDS >> 1))
    else $error("two inputs not given half memory");
  abort_cause_a: assert property (acq_abort |-> $past(acq_running) && !acq_running)
    else $error("abort without a run or run kept going");
  mem_cause_a: assert property ($rose(mem_valid) |-> $past(acq_done) && $past(acq_running))
    else $error("memory valid without a finished run");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  cover property (acq_abort);
  cover property ($rose(low_power));
  cover property (acq_running && chan_run_mask == BCCE_MASK_BOTH);
endmodule

bind bcce_top bcce_properties #(.MEM_AW(MEM_AW)) u_props (.clk, .resetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .acq_done, .low_power,
  .mem_valid, .acq_running, .acq_start, .acq_abort, .chan_run_mask, .chan_mem_words);

// >>> verification/bcce_top_bench.sv
// register-level bench for board command and channel activation
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("Error %0t: got %h expected %h", $time, a, b); end end
module bcce_top_bench;
  import bcce_pkg::*;
  logic clk = 0, resetn = 0, acq_done = 0;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic low_power, mem_valid, acq_running, acq_start, acq_abort;
  logic [1:0] chan_run_mask;
  logic [7:0] chan_mem_words;
  int fails = 0, n_checks = 0, cyc = 0, n_abort = 0, n_start = 0;
  logic [31:0] wm [4] = '{32'h0000_0003, 32'h0000_0002, 32'h0000_0000, 32'h0000_0004};
  logic [31:0] em [4] = '{32'h0000_0003, 32'h0000_0003, 32'h0000_0001, 32'h0000_0001};
  // small memory address width keeps the split values short
  bcce_top #(.MEM_AW(8)) DUT (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acq_done, .low_power, .mem_valid,
    .acq_running, .acq_start, .acq_abort, .chan_run_mask, .chan_mem_words);
  always #10 clk = ~clk;
  task results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (acq_abort === 1'b1)
      n_abort++;
    if (acq_start === 1'b1)
      n_start++;
    // generous ceiling: a few dozen bus cycles of under ten clocks each
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  task wr(input logic [17:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge clk);
  endtask
  task rd(input logic [17:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge clk);
  endtask
  task done_pulse;
    acq_done <= 1;
    @(posedge clk);
    acq_done <= 0;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    rd(BCCE_ADDR_CHAN);
    `CHK(rdat, 32'h0000_0001)
    rd(BCCE_ADDR_COMMAND);
    `CHK(rdat, 32'h0000_0000)
    for (int i = 0; i < 4; i++) begin
      wr(BCCE_ADDR_CHAN, wm[i]);
      rd(BCCE_ADDR_CHAN);
      `CHK(rdat, em[i])
    end
    wr(BCCE_ADDR_CHAN, 32'h0000_0001 | 32'h0000_0002);
    `CHK(resp, BCCE_RESP_OKAY)
    wr(BCCE_ADDR_RUN, 32'h0000_0001);
    `CHK({acq_running, chan_run_mask}, 3'b111)
    `CHK(chan_mem_words, 8'h7F)
    `CHK(n_start, 1)
    done_pulse();
    `CHK(mem_valid, 1'b1)
    wr(BCCE_ADDR_COMMAND, BCCE_CMD_LOW_POWER);
    `CHK({low_power, mem_valid}, 2'b10)
    rd(BCCE_ADDR_COMMAND);
    `CHK(rdat, BCCE_CMD_LOW_POWER)
    wr(BCCE_ADDR_RUN, 32'h0000_0001);
    `CHK({low_power, acq_running}, 2'b01)
    // a new mask must not disturb the run already going
    wr(BCCE_ADDR_CHAN, 32'h0000_0001);
    `CHK(chan_run_mask, 2'h3)
    wr(BCCE_ADDR_COMMAND, BCCE_CMD_LOW_POWER);
    `CHK({n_abort, acq_running, low_power}, {32'd1, 2'b01})
    wr(BCCE_ADDR_RUN, 32'h0000_0001);
    wr(BCCE_ADDR_CHAN, 32'h0000_0003);
    wr(BCCE_ADDR_COMMAND, BCCE_CMD_FULL_RESET);
    `CHK({n_abort, acq_running, low_power}, {32'd2, 2'b00})
    rd(BCCE_ADDR_CHAN);
    `CHK(rdat, 32'h0000_0001)
    wr(BCCE_ADDR_RUN, 32'h0000_0001);
    `CHK({chan_run_mask, chan_mem_words}, 10'h1FF)
    // a start while running is ignored; the stop bit aborts the run
    wr(BCCE_ADDR_RUN, 32'h0000_0001);
    `CHK(n_start, 4)
    wr(BCCE_ADDR_RUN, 32'h0000_0002);
    `CHK({n_abort, acq_running}, {32'd3, 1'b0})
    rd(BCCE_ADDR_STATUS);
    `CHK(rdat, 32'h0000_0010)
    wr(18'h0_0100, 32'h0000_0003);
    `CHK(resp, BCCE_RESP_SLVERR)
    rd(18'h0_0100);
    `CHK({resp, rdat}, {BCCE_RESP_SLVERR, 32'h0000_0000})
    // low byte lane off: the write is refused and the mask kept
    s_axi_wstrb <= 4'hE;
    wr(BCCE_ADDR_CHAN, 32'h0000_0003);
    `CHK(resp, BCCE_RESP_SLVERR)
    rd(BCCE_ADDR_CHAN);
    `CHK(rdat, 32'h0000_0001)
    results();
  end
endmodule
